// ### src/trig_pkg.sv
// Purpose: constants and types for the trigger input/output block
// Assumes: 40 MHz mclk, APB register access with 32-bit data
// Notes: all offsets are byte addresses of aligned words
package trig_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [5:0] WIDTH_MAX_MS = 6'h3c;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  // register byte offsets
  localparam logic [7:0] OFF_IN_CFG = 8'h00;
  localparam logic [7:0] OFF_OUT_CFG = 8'h04;
  localparam logic [7:0] OFF_SETPT = 8'h08;
  localparam logic [7:0] OFF_CFG_SESSION = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_SW_EVENT = 8'h14;
  localparam logic [7:0] OFF_APPLIED = 8'h18;
  localparam logic [7:0] OFF_PWRON_CFG = 8'h1c;
  // in_cfg fields
  localparam int IN_WIDTH_LSB = 0;
  localparam int ACTION_LSB = 8;
  localparam int OUT_STATE_BIT = 10;
  localparam int SLOT_LSB = 12;
  // out_cfg fields
  localparam int OUT_WIDTH_LSB = 0;
  localparam int LEVEL_BIT = 8;
  localparam int SOURCE_LSB = 12;
  // setpoint fields
  localparam int VSET_LSB = 0;
  localparam int ISET_LSB = 16;
  localparam logic [15:0] RATED_VOLT = 16'hffff;
  localparam logic [15:0] RATED_CURR = 16'hffff;
  // software event bits
  localparam int EV_OUT_BIT = 0;
  localparam int EV_SET_BIT = 1;
  localparam int EV_MEM_BIT = 2;
  localparam logic [31:0] PWRON_RESET = 32'h00000000;

  typedef enum logic [1:0] {ACT_NONE, ACT_OUTPUT, ACT_SETTING, ACT_MEMORY} action_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_OUTPUT, SRC_SETTING, SRC_MEMORY} source_t;

  typedef struct packed {
    logic [5:0] in_width;
    action_t action;
    logic out_state;
    logic [1:0] slot;
  } in_cfg_t;

  typedef struct packed {
    logic [5:0] out_width;
    logic level;
    source_t source;
  } out_cfg_t;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
  } setpt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : trig_pkg

// ### src/trigger_io.sv
// Purpose: trigger input qualification, trigger action, trigger output
// Assumes: trigger_input_line synchronous to mclk, active high
// Notes: one clock; a millisecond tick times both widths
// What this block does
// [RULE1] An input trigger is qualified by a 0-60 ms width, or by level when the width is 0.
// [RULE2] A two-bit action code picks none, output switch, setpoints, or setup recall.
// [RULE3] With output-switch action, a trigger drives the output to the configured state.
// [RULE4] Only with action 2 are voltage and current setpoints loaded, each clamped to rating.
// [RULE5] With memory action, a trigger recalls stored setup one, two or three by slot code.
// [RULE6] The output trigger pulses for 0-60 ms, and holds its active level when width is 0.
// [RULE7] With zero output width a one-bit polarity sets the active level, 0 low, 1 high.
// [RULE8] A source code picks which event emits the output trigger: none, output, setting, recall.
// [RULE9] The power-on group is writable only in the power-up configuration session.
// [RULE10] A trigger input line and a trigger output line are provided; the outside drives input.
// [RULE11] Widths are timed by a millisecond tick that restarts with each new trigger event.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module trigger_io (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic trigger_input_line, // external trigger, active high
  output logic trigger_output_line, // trigger to outside
  output logic out_enable, // output power stage on
  output logic [15:0] volt_setpoint, // applied voltage setpoint
  output logic [15:0] curr_setpoint, // applied current setpoint
  output logic recall_strobe, // one-cycle request to restore a setup
  output logic [1:0] recall_slot // setup slot being restored
);
  ////////////////////////////////////////////////////////////////////////
  // register bus
  trig_pkg::apb_req_t req;
  trig_pkg::in_cfg_t in_cfg_q, in_cfg_d;
  trig_pkg::out_cfg_t out_cfg_q, out_cfg_d;
  trig_pkg::setpt_t setpt_q, setpt_d;
  logic session_q, session_d;
  logic [31:0] pwron_q, pwron_d;
  logic [2:0] sw_ev;
  logic wr, rd_ok;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign pready = 1'b1; // zero wait states
  assign wr = req.psel && req.penable && req.pwrite;
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == trig_pkg::OFF_IN_CFG) || (a == trig_pkg::OFF_OUT_CFG) ||
             (a == trig_pkg::OFF_SETPT) || (a == trig_pkg::OFF_CFG_SESSION) ||
             (a == trig_pkg::OFF_STATUS) || (a == trig_pkg::OFF_SW_EVENT) ||
             (a == trig_pkg::OFF_APPLIED) || (a == trig_pkg::OFF_PWRON_CFG);
  endfunction : mapped
  function automatic logic [5:0] clamp_ms(input logic [5:0] v);
    clamp_ms = (v > trig_pkg::WIDTH_MAX_MS) ? trig_pkg::WIDTH_MAX_MS : v;
  endfunction : clamp_ms
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction : clamp16
  assign rd_ok = mapped(req.paddr);
  assign pslverr = req.psel && req.penable && !rd_ok;

  // configuration writes; widths are clamped so timing never exceeds 60 ms
  always_comb
  begin
    in_cfg_d = in_cfg_q;
    out_cfg_d = out_cfg_q;
    setpt_d = setpt_q;
    session_d = session_q;
    pwron_d = pwron_q;
    sw_ev = 3'h0;
    if (wr)
    begin
      case (req.paddr)
        trig_pkg::OFF_IN_CFG:
        begin
          in_cfg_d.in_width = clamp_ms(req.pwdata[trig_pkg::IN_WIDTH_LSB +: 6]); // [RULE1]
          in_cfg_d.action = trig_pkg::action_t'(req.pwdata[trig_pkg::ACTION_LSB +: 2]);
          in_cfg_d.out_state = req.pwdata[trig_pkg::OUT_STATE_BIT];
          in_cfg_d.slot = req.pwdata[trig_pkg::SLOT_LSB +: 2];
        end
        trig_pkg::OFF_OUT_CFG:
        begin
          out_cfg_d.out_width = clamp_ms(req.pwdata[trig_pkg::OUT_WIDTH_LSB +: 6]); // [RULE6]
          out_cfg_d.level = req.pwdata[trig_pkg::LEVEL_BIT]; // [RULE7]
          out_cfg_d.source = trig_pkg::source_t'(req.pwdata[trig_pkg::SOURCE_LSB +: 2]);
        end
        trig_pkg::OFF_SETPT:
        begin
          setpt_d.volt = clamp16(req.pwdata[trig_pkg::VSET_LSB +: 16], trig_pkg::RATED_VOLT);
          setpt_d.curr = clamp16(req.pwdata[trig_pkg::ISET_LSB +: 16], trig_pkg::RATED_CURR);
        end
        // session can only be closed by software; it opens only out of reset
        trig_pkg::OFF_CFG_SESSION: session_d = session_q & req.pwdata[0]; // [RULE9]
        trig_pkg::OFF_PWRON_CFG: if (session_q) pwron_d = req.pwdata; // [RULE9]
        trig_pkg::OFF_SW_EVENT: sw_ev = req.pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_cfg_q <= '0;
      out_cfg_q <= '0;
      setpt_q <= '0;
      session_q <= 1'b1; // power-up session open after reset
      pwron_q <= trig_pkg::PWRON_RESET;
    end
    else
    begin
      in_cfg_q <= in_cfg_d;
      out_cfg_q <= out_cfg_d;
      setpt_q <= setpt_d;
      session_q <= session_d;
      pwron_q <= pwron_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick, restarted by each new trigger event
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic restart;

  always_comb
  begin
    tick = (tick_cnt_q == trig_pkg::TICK_LAST);
    tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    if (restart)
      tick_cnt_d = 16'h0000; // [RULE11]
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // input qualification
  logic in_q, in_d;
  logic [5:0] in_ms_q, in_ms_d;
  logic qual_q, qual_d;
  logic fire;
  logic out_restart;

  // a timed trigger must stay active for the full width before it counts
  always_comb
  begin
    in_d = trigger_input_line; // [RULE10]
    in_ms_d = in_ms_q;
    qual_d = qual_q;
    if (!trigger_input_line)
    begin
      in_ms_d = 6'h00;
      qual_d = 1'b0;
    end
    else if (in_cfg_q.in_width == 6'h00)
      qual_d = 1'b1; // level controlled [RULE1]
    else if (!qual_q && tick)
    begin
      in_ms_d = in_ms_q + 6'h01;
      if (in_ms_d >= in_cfg_q.in_width)
        qual_d = 1'b1; // [RULE1]
    end
    fire = qual_d && !qual_q;
  end

  assign restart = (trigger_input_line && !in_q) || out_restart; // [RULE11]

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_q <= 1'b0;
      in_ms_q <= '0;
      qual_q <= 1'b0;
    end
    else
    begin
      in_q <= in_d;
      in_ms_q <= in_ms_d;
      qual_q <= qual_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger action
  logic out_en_q, out_en_d;
  logic [15:0] volt_q, volt_d, curr_q, curr_d;
  logic rc_q, rc_d;
  logic [1:0] slot_q, slot_d;
  logic ev_out, ev_set, ev_mem;

  always_comb
  begin
    out_en_d = out_en_q;
    volt_d = volt_q;
    curr_d = curr_q;
    rc_d = 1'b0;
    slot_d = slot_q;
    ev_out = sw_ev[trig_pkg::EV_OUT_BIT];
    ev_set = sw_ev[trig_pkg::EV_SET_BIT];
    ev_mem = sw_ev[trig_pkg::EV_MEM_BIT];
    if (fire)
    begin
      case (in_cfg_q.action) // [RULE2]
        trig_pkg::ACT_NONE: ;
        trig_pkg::ACT_OUTPUT:
        begin
          out_en_d = in_cfg_q.out_state; // [RULE3]
          ev_out = 1'b1;
        end
        trig_pkg::ACT_SETTING:
        begin
          volt_d = setpt_q.volt; // [RULE4]
          curr_d = setpt_q.curr; // [RULE4]
          ev_set = 1'b1;
        end
        trig_pkg::ACT_MEMORY:
        begin
          // slot code 0 names no setup, so nothing is recalled
          if (in_cfg_q.slot != 2'h0)
          begin
            rc_d = 1'b1; // [RULE5]
            slot_d = in_cfg_q.slot; // [RULE5]
            ev_mem = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_en_q <= 1'b0;
      volt_q <= '0;
      curr_q <= '0;
      rc_q <= 1'b0;
      slot_q <= '0;
    end
    else
    begin
      out_en_q <= out_en_d;
      volt_q <= volt_d;
      curr_q <= curr_d;
      rc_q <= rc_d;
      slot_q <= slot_d;
    end
  end

  assign out_enable = out_en_q;
  assign volt_setpoint = volt_q;
  assign curr_setpoint = curr_q;
  assign recall_strobe = rc_q;
  assign recall_slot = slot_q;

  ////////////////////////////////////////////////////////////////////////
  // output trigger
  logic out_act_q, out_act_d;
  logic [5:0] out_ms_q, out_ms_d;
  logic emit;
  logic line_q, line_d;

  always_comb
  begin
    case (out_cfg_q.source) // [RULE8]
      trig_pkg::SRC_OUTPUT: emit = ev_out;
      trig_pkg::SRC_SETTING: emit = ev_set;
      trig_pkg::SRC_MEMORY: emit = ev_mem;
      default: emit = 1'b0;
    endcase
    out_restart = emit;
    out_act_d = out_act_q;
    out_ms_d = out_ms_q;
    if (emit)
    begin
      out_act_d = 1'b1;
      out_ms_d = 6'h00;
    end
    else if (out_act_q && out_cfg_q.out_width != 6'h00 && tick)
    begin
      out_ms_d = out_ms_q + 6'h01;
      if (out_ms_d >= out_cfg_q.out_width)
        out_act_d = 1'b0; // pulse ends [RULE6]
    end
    // zero width: held at the chosen level once emitted; otherwise high pulse
    if (out_cfg_q.out_width == 6'h00)
      line_d = out_act_d ? out_cfg_q.level : !out_cfg_q.level; // [RULE7]
    else
      line_d = out_act_d; // [RULE6]
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_act_q <= 1'b0;
      out_ms_q <= '0;
      line_q <= 1'b1; // idle of the reset config: zero width, active low, so no false edge
    end
    else
    begin
      out_act_q <= out_act_d;
      out_ms_q <= out_ms_d;
      line_q <= line_d;
    end
  end

  assign trigger_output_line = line_q; // [RULE10]

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    prdata = 32'h00000000;
    case (req.paddr)
      trig_pkg::OFF_IN_CFG:
        prdata = {18'h0, in_cfg_q.slot, 1'b0, in_cfg_q.out_state, in_cfg_q.action, 2'h0,
                  in_cfg_q.in_width};
      trig_pkg::OFF_OUT_CFG:
        prdata = {18'h0, out_cfg_q.source, 3'h0, out_cfg_q.level, 2'h0, out_cfg_q.out_width};
      trig_pkg::OFF_SETPT: prdata = {setpt_q.curr, setpt_q.volt};
      trig_pkg::OFF_CFG_SESSION: prdata = {31'h0, session_q};
      trig_pkg::OFF_STATUS: prdata = {28'h0, line_q, out_act_q, qual_q, out_en_q};
      trig_pkg::OFF_APPLIED: prdata = {curr_q, volt_q};
      trig_pkg::OFF_PWRON_CFG: prdata = pwron_q;
      default: prdata = 32'h00000000;
    endcase
  end
endmodule : trigger_io

// ### test/trig_fixture.sv
// Purpose: model of the outside fixture that drives the trigger input
// Assumes: one clock, fixture idles its line low
// Notes: a fire request holds the line high for hold cycles
`timescale 1ns/1ps
module trig_fixture (
  input wire logic mclk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic fire, // start one trigger
  input wire logic [16:0] hold, // cycles the line stays high
  output logic trigger_input_line // line into the device
);
  logic [16:0] left_q;
  logic [16:0] left_d;
  // count down the high time; a new fire restarts it
  always_comb
  begin
    left_d = left_q;
    if (fire)
      left_d = hold;
    else if (left_q != 17'h00000)
      left_d = left_q - 17'h00001;
  end
  // registered so the line changes only after an edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      left_q <= 17'h00000;
    else
      left_q <= left_d;
  end
  // the fixture owns this line and drives it at all times
  assign trigger_input_line = (left_q != 17'h00000);
endmodule : trig_fixture

// ### test/trig_monitor.sv
// Purpose: port checker for the trigger block
// Assumes: one clock domain, async active-low reset
// Notes: ties each setpoint and enable change, and each rise of the recall strobe and trigger out, to its cause at the inputs; each slot change to the strobe
`timescale 1ns/1ps
module trig_monitor (
  input wire logic mclk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic trigger_input_line, // trigger in
  input wire logic trigger_output_line, // trigger out
  input wire logic out_enable, // output on
  input wire logic [15:0] volt_setpoint, // voltage setpoint
  input wire logic [15:0] curr_setpoint, // current setpoint
  input wire logic recall_strobe, // recall pulse
  input wire logic [1:0] recall_slot // recall slot
);
  logic wr;
  // a completed apb write, the only software cause of an output event
  assign wr = psel && penable && pwrite;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  chk_recall_rearm: assert property (recall_strobe |=> !recall_strobe [*3])
    else $error("recall strobe repeated");
  chk_recall_slot: assert property (recall_strobe |-> recall_slot != 2'h0)
    else $error("recall with slot zero");
  chk_slot_change: assert property ($changed(recall_slot) |-> recall_strobe)
    else $error("slot moved without recall");
  // an action registers on the first edge that samples the qualified line high
  chk_recall_cause: assert property ($rose(recall_strobe) |-> $past(trigger_input_line))
    else $error("recall without trigger");
  chk_volt_cause: assert property ($changed(volt_setpoint) |-> $past(trigger_input_line))
    else $error("voltage moved without trigger");
  chk_curr_cause: assert property ($changed(curr_setpoint) |-> $past(trigger_input_line))
    else $error("current moved without trigger");
  chk_outen_cause: assert property ($changed(out_enable) |-> $past(trigger_input_line))
    else $error("output switched without trigger");
  chk_tout_cause: assert property ($rose(trigger_output_line) |->
    $past(wr) || $past(wr, 2) || $past(trigger_input_line))
    else $error("trigger out rose without event");
endmodule : trig_monitor
bind trigger_io trig_monitor mon (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .trigger_input_line(trigger_input_line),
  .trigger_output_line(trigger_output_line), .out_enable(out_enable),
  .volt_setpoint(volt_setpoint), .curr_setpoint(curr_setpoint),
  .recall_strobe(recall_strobe), .recall_slot(recall_slot));

// ### test/tb_top.sv
// Purpose: self-checking bench for the trigger block
// Assumes: 40 MHz clock, zero-wait apb slave
// Notes: the millisecond cases run the full 40000-cycle tick
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic fire = 1'b0;
  logic [16:0] hold = 17'h00000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, tin, tout, out_en, rstb;
  logic [15:0] volt, curr;
  logic [1:0] slot;
  int err_total = 0;
  int tests_run = 0;
  trigger_io uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input_line(tin), .trigger_output_line(tout), .out_enable(out_en),
    .volt_setpoint(volt), .curr_setpoint(curr), .recall_strobe(rstb), .recall_slot(slot));
  trig_fixture fix (.mclk(mclk), .rst_n(rst_n), .fire(fire), .hold(hold),
    .trigger_input_line(tin));
  // free-running 25 ns clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////
  task end_sim;
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task hang;
    err_total++;
    end_sim();
  endtask : hang
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
      hang();
  endtask : apb
  task settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  // program the input side, then fire the fixture for n cycles
  task arm(input logic [31:0] cfg, input int n);
    apb(1'b1, trig_pkg::OFF_IN_CFG, cfg);
    @(posedge mclk);
    fire <= 1'b1;
    hold <= 17'(n);
    @(posedge mclk);
    fire <= 1'b0;
  endtask : arm
  task do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////
  task t_reset;
    apb(1'b0, trig_pkg::OFF_CFG_SESSION, 32'h0);
    `CHK("session", 32'h00000001, rdat)
    // reset config is zero width with an active-low level, so the idle line is high
    `CHK("tout idle", 1'b1, tout)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h00000000, rdat)
  endtask : t_reset
  task t_action;
    apb(1'b1, trig_pkg::OFF_SETPT, 32'h12345678);
    arm(32'h00000000, 4);
    settle(4);
    `CHK("no action", 16'h0000, volt)
    arm(32'h00000500, 4);
    settle(4);
    `CHK("out on", 1'b1, out_en)
    arm(32'h00000100, 4);
    settle(4);
    `CHK("out off", 1'b0, out_en)
    arm(32'h00000200, 4);
    settle(4);
    `CHK("volt", 16'h5678, volt)
    `CHK("curr", 16'h1234, curr)
  endtask : t_action
  // each non-zero slot code, waiting on the recall strobe itself
  task t_recall;
    int s, i;
    for (s = 1; s < 4; s++)
    begin
      arm(32'h00000300 | (s << 12), 4);
      for (i = 0; i < 10 && rstb !== 1'b1; i++)
        @(negedge mclk);
      if (i == 10)
        hang();
      `CHK("slot", 2'(s), slot)
      settle(4);
    end
    // slot code zero names no setup: the last recalled slot must stay put
    arm(32'h00000300, 4);
    settle(6);
    `CHK("slot zero", 2'h3, slot)
  endtask : t_recall
  task t_source;
    apb(1'b1, trig_pkg::OFF_OUT_CFG, 32'h00000100);
    apb(1'b1, trig_pkg::OFF_SW_EVENT, 32'h00000003);
    settle(2);
    `CHK("src none", 1'b0, tout)
    apb(1'b1, trig_pkg::OFF_OUT_CFG, 32'h00001100);
    apb(1'b1, trig_pkg::OFF_SW_EVENT, 32'h00000002);
    settle(2);
    `CHK("src other", 1'b0, tout)
    apb(1'b1, trig_pkg::OFF_SW_EVENT, 32'h00000001);
    settle(2);
    `CHK("level high", 1'b1, tout)
    settle(100);
    `CHK("level held", 1'b1, tout)
  endtask : t_source
  task t_session;
    apb(1'b1, trig_pkg::OFF_PWRON_CFG, 32'h000000a5);
    apb(1'b0, trig_pkg::OFF_PWRON_CFG, 32'h0);
    `CHK("pwron open", 32'h000000a5, rdat)
    apb(1'b1, trig_pkg::OFF_CFG_SESSION, 32'h0);
    apb(1'b1, trig_pkg::OFF_PWRON_CFG, 32'h0000005a);
    apb(1'b0, trig_pkg::OFF_PWRON_CFG, 32'h0);
    `CHK("pwron locked", 32'h000000a5, rdat)
    apb(1'b1, trig_pkg::OFF_CFG_SESSION, 32'h1);
    apb(1'b0, trig_pkg::OFF_CFG_SESSION, 32'h0);
    `CHK("no reopen", 32'h00000000, rdat)
  endtask : t_session
  // 1 ms qualification; an unrestarted tick would fire 6 cycles early, still after the early check
  task t_widths;
    arm(32'h00000501, 40100);
    settle(39990);
    `CHK("in early", 1'b0, out_en)
    settle(40);
    `CHK("in qual", 1'b1, out_en)
    apb(1'b1, trig_pkg::OFF_OUT_CFG, 32'h00002001);
    apb(1'b1, trig_pkg::OFF_SW_EVENT, 32'h00000002);
    settle(1);
    `CHK("pulse start", 1'b1, tout)
    settle(39970);
    `CHK("pulse high", 1'b1, tout)
    settle(60);
    `CHK("pulse end", 1'b0, tout)
  endtask : t_widths
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    t_reset();
    t_action();
    t_recall();
    t_source();
    t_session();
    do_reset();
    t_widths();
    end_sim();
  end
endmodule : tb_top
